// ---- inc/pnc_pkg.sv ----
// constants for the partner next page and phy control register bank
package pnc_pkg;

    // register port widths
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;

    // register offsets
    localparam logic [ADDR_W-1:0] OFS_PARTNER_NP = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_PHY_CTRL   = 5'h10;

    // partner next page code word fields
    localparam int NP_MORE_PAGES_BIT = 15;
    localparam int NP_ACK_BIT        = 14;
    localparam int NP_MESSAGE_BIT    = 13;
    localparam int NP_ACK_TWO_BIT    = 12;
    localparam int NP_TOGGLE_BIT     = 11;
    localparam int NP_PAYLOAD_MSB    = 10;
    localparam int NP_PAYLOAD_LSB    = 0;
    localparam logic [DATA_W-1:0] NP_RESET = 16'h0000;

    // phy specific control fields
    localparam int CTL_RSVD15_BIT      = 15;
    localparam int CTL_ENERGY_BIT      = 14;
    localparam int CTL_LP_CHECK_BIT    = 13;
    localparam int CTL_NP_ROUTE_BIT    = 12;
    localparam int CTL_LP_GEN_BIT      = 11;
    localparam int CTL_RSVD10_BIT      = 10;
    localparam int CTL_SCRAMBLER_BIT   = 9;
    localparam int CTL_FAR_FAULT_BIT   = 8;
    localparam int CTL_LONG_CABLE_BIT  = 7;
    localparam int CTL_SD_POLARITY_BIT = 6;
    localparam int CTL_XOVER_MSB       = 5;
    localparam int CTL_XOVER_LSB       = 4;
    localparam int CTL_RSVD3_BIT       = 3;
    localparam int CTL_HEARTBEAT_BIT   = 2;
    localparam int CTL_AUTO_POL_BIT    = 1;
    localparam int CTL_JABBER_BIT      = 0;

    // hardware reset value with strap-dependent fields at zero
    localparam logic [DATA_W-1:0] CTL_HW_RESET = 16'h0100;
    // bits kept by a software reset (15, 14, 9, 8, 6, 5:4, 3, 2)
    localparam logic [DATA_W-1:0] CTL_SW_KEEP  = 16'hc37c;
    // value of the fields that a software reset returns
    localparam logic [DATA_W-1:0] CTL_SW_RESET = 16'h0000;

    // crossover field codes
    localparam logic [1:0] XOVER_STRAIGHT = 2'h0;
    localparam logic [1:0] XOVER_SWAPPED  = 2'h1;
    localparam logic [1:0] XOVER_AUTO     = 2'h3;

    // read answer for unmapped addresses
    localparam logic [DATA_W-1:0] RD_UNMAPPED = 16'h0000;

endpackage

// ---- rtl/pnc_page_store.sv ----
// partner next page code word store
`timescale 1ns/100ps

module pnc_page_store
    import pnc_pkg::*;
(
    input  wire logic              mclk,          // system clock
    input  wire logic              resetn,        // synchronous reset, active low
    input  wire logic              sw_reset,      // software reset pulse
    input  wire logic              route_np,      // next page routing enabled
    input  wire logic              page_valid,    // received next page strobe
    input  wire logic [DATA_W-1:0] page_code,     // received code word
    output logic      [DATA_W-1:0] code_r         // stored code word
);

    // store or clear the code word
    always_ff @(posedge mclk) begin
        if (!resetn || sw_reset) begin
            code_r <= NP_RESET;                  // both resets give all zeros
        end else if (!route_np) begin
            code_r <= NP_RESET;                  // [R3]
        end else if (page_valid) begin
            code_r <= page_code;                 // bit for bit copy [R1] [R4] [R5]
        end
    end

endmodule // pnc_page_store

// ---- rtl/pnc_regs.sv ----
// partner next page and phy specific control register bank
//
// Summary of operation
// R1 - routing on: next pages go to partner register
// R2 - routing off: next pages overwrite base page
// R3 - routing off: partner register reads all zeros
// R4 - code word bits map one to one
// R5 - acknowledge shows partner next page capability
// R6 - bit 14 enables energy sense and pulse
// R7 - bit 13 disables receive link pulse check
// R8 - bit 11 stops link pulse generation
// R9 - link pulse disables ignored under auto-negotiation
// R10 - scrambler off at reset for fiber, forced 10
// R11 - far fault off resets one, copper suppresses
// R12 - bit 7 lowers 10 megabit receive threshold
// R13 - bit 6 sets signal detect polarity
// R14 - crossover 00 straight, 01 swapped, 1x auto
// R15 - crossover resets from strap: 00 or 11
// R16 - written crossover applies after software reset
// R17 - bit 2 heartbeat test, off in full duplex
// R18 - bit 1 clear enables 10 megabit auto polarity
// R19 - bit 0 disables jabber; none in full/100
// R20 - software reset keeps, updates or clears fields
//
// The plain strobed port was decided locally.
`timescale 1ns/100ps

module pnc_regs
    import pnc_pkg::*;
(
    input  wire logic                      mclk,                       // system clock, 200 MHz
    input  wire logic                      resetn,                     // synchronous hardware reset, active low
    input  wire logic [pnc_pkg::ADDR_W-1:0] reg_addr,                  // register address
    input  wire logic [pnc_pkg::DATA_W-1:0] reg_wdata,                 // register write data
    input  wire logic                      reg_wr,                     // write strobe
    input  wire logic                      reg_rd,                     // read strobe
    output logic      [pnc_pkg::DATA_W-1:0] reg_rdata_r,               // read data, cycle after strobe
    input  wire logic                      sw_reset,                   // software reset pulse
    input  wire logic                      crossover_strap,            // crossover strap level
    input  wire logic                      fiber_strap,                // fiber 100 mode selected
    input  wire logic                      forced10_strap,             // forced 10 megabit mode selected
    input  wire logic                      page_rx_valid,              // next page received strobe
    input  wire logic [pnc_pkg::DATA_W-1:0] page_rx_code,              // received next page code word
    input  wire logic                      aneg_enable,                // local auto-negotiation enabled
    input  wire logic                      full_duplex,                // operating full duplex
    input  wire logic                      speed_100,                  // operating at 100 megabit
    input  wire logic                      fiber_mode,                 // fiber mode, low means copper
    input  wire logic                      fiber_signal_detect,        // raw fiber signal detect input
    output logic                           base_page_load_r,           // base page write pulse
    output logic      [pnc_pkg::DATA_W-1:0] base_page_code_r,          // code word for base page
    output logic                           next_page_routing_r,        // routing enable to negotiation
    output logic                           energy_sense_enable_r,      // energy detect sense and pulse
    output logic                           link_pulse_check_off_r,     // receive link pulse check off
    output logic                           link_pulse_gen_off_r,       // link pulse generation off
    output logic                           scrambler_off_r,            // scrambler bypass
    output logic                           far_fault_enable_r,         // far end fault indication active
    output logic                           long_cable_threshold_r,     // lowered receive threshold
    output logic                           signal_detect_r,            // conditioned signal detect, high true
    output logic                           crossover_swap_r,           // manual swapped pairs
    output logic                           crossover_auto_r,           // automatic crossover active
    output logic                           heartbeat_test_active_r,    // heartbeat test running
    output logic                           auto_polarity_enable_r,     // automatic polarity correction on
    output logic                           force_normal_polarity_r,    // 10 megabit polarity forced normal
    output logic                           jabber_guard_active_r       // jabber function active
);

    import pnc_pkg::*;

    // keep-mask merge used for software reset shaping; hardware reset ORs strap fields into CTL_HW_RESET
    function automatic logic [DATA_W-1:0] merge_keep(
        input logic [DATA_W-1:0] old_val,
        input logic [DATA_W-1:0] new_val,
        input logic [DATA_W-1:0] keep
    );
        merge_keep = (old_val & keep) | (new_val & ~keep);
    endfunction

    // a disable bit only bites when its own blocking condition is absent
    function automatic logic gated_bit(
        input logic bit_val,
        input logic block
    );
        gated_bit = bit_val & ~block;
    endfunction

    // control register contents as software sees them
    logic [DATA_W-1:0] ctrl_r;
    logic [DATA_W-1:0] ctrl_nxt;
    // crossover setting actually in force
    logic [1:0]        xover_live_r;
    logic [1:0]        xover_live_nxt;
    // stored partner next page word
    logic [DATA_W-1:0] partner_np;

    // address decode
    wire hit_np   = (reg_addr == OFS_PARTNER_NP);   // partner next page selected
    wire hit_ctrl = (reg_addr == OFS_PHY_CTRL);     // control register selected
    wire wr_ctrl  = reg_wr & hit_ctrl;              // write lands on control register

    // strap-derived hardware reset value
    wire [1:0]        xover_strap_val = crossover_strap ? XOVER_AUTO : XOVER_STRAIGHT;  // [R15]
    wire              scram_strap_val = fiber_strap | forced10_strap;                   // [R10]
    wire [DATA_W-1:0] ctrl_hw_val     = CTL_HW_RESET
                                      | ({{(DATA_W-2){1'b0}}, xover_strap_val} << CTL_XOVER_LSB)
                                      | ({{(DATA_W-1){1'b0}}, scram_strap_val} << CTL_SCRAMBLER_BIT);

    // software reset: retained and updated fields kept, the rest cleared
    wire [DATA_W-1:0] ctrl_sw_val = merge_keep(ctrl_r, CTL_SW_RESET, CTL_SW_KEEP);  // [R20]

    // read multiplexer; write-only or unmapped addresses answer zero
    wire [DATA_W-1:0] rd_mux = hit_np   ? partner_np :
                               hit_ctrl ? ctrl_r     :
                                          RD_UNMAPPED;

    // control fields split out by name
    wire route_bit      = ctrl_r[CTL_NP_ROUTE_BIT];
    wire energy_bit     = ctrl_r[CTL_ENERGY_BIT];
    wire lp_check_bit   = ctrl_r[CTL_LP_CHECK_BIT];
    wire lp_gen_bit     = ctrl_r[CTL_LP_GEN_BIT];
    wire scram_bit      = ctrl_r[CTL_SCRAMBLER_BIT];
    wire far_fault_bit  = ctrl_r[CTL_FAR_FAULT_BIT];
    wire long_cable_bit = ctrl_r[CTL_LONG_CABLE_BIT];
    wire sd_pol_bit     = ctrl_r[CTL_SD_POLARITY_BIT];
    wire heartbeat_bit  = ctrl_r[CTL_HEARTBEAT_BIT];
    wire auto_pol_bit   = ctrl_r[CTL_AUTO_POL_BIT];
    wire jabber_bit     = ctrl_r[CTL_JABBER_BIT];

    // control register next value
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (sw_reset) begin
            // software reset wins over a write in the same cycle
            ctrl_nxt = ctrl_sw_val;              // [R20]
        end else if (wr_ctrl) begin
            // every bit is read/write, reserved ones included
            ctrl_nxt = reg_wdata;                // [R16]
        end
    end

    // crossover in force only moves on a reset, so a write alone
    // never disturbs a link that is already up
    always_comb begin
        xover_live_nxt = xover_live_r;
        if (sw_reset) begin
            xover_live_nxt = ctrl_r[CTL_XOVER_MSB:CTL_XOVER_LSB];  // [R16]
        end
    end

    // control register and live crossover state
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ctrl_r       <= ctrl_hw_val;         // straps caught while reset is held [R10] [R11] [R15]
            xover_live_r <= xover_strap_val;     // [R15]
        end else begin
            ctrl_r       <= ctrl_nxt;
            xover_live_r <= xover_live_nxt;
        end
    end

    // partner next page store
    pnc_page_store u_page_store (
        .mclk       (mclk),
        .resetn     (resetn),
        .sw_reset   (sw_reset),
        .route_np   (route_bit),
        .page_valid (page_rx_valid),
        .page_code  (page_rx_code),
        .code_r     (partner_np)
    );

    // base page path: with routing off every next page overwrites it
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            base_page_load_r <= 1'b0;
            base_page_code_r <= NP_RESET;
        end else begin
            base_page_load_r <= page_rx_valid & ~route_bit;   // [R1] [R2]
            if (page_rx_valid & ~route_bit) begin
                base_page_code_r <= page_rx_code;             // [R2]
            end
        end
    end

    // read data register; holds only in the cycle after the strobe
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            reg_rdata_r <= RD_UNMAPPED;
        end else if (reg_rd) begin
            reg_rdata_r <= rd_mux;               // [R4]
        end else begin
            reg_rdata_r <= RD_UNMAPPED;
        end
    end

    // effective controls for the datapath
    wire lp_check_eff   = gated_bit(lp_check_bit, aneg_enable);              // [R7] [R9]
    wire lp_gen_eff     = gated_bit(lp_gen_bit, aneg_enable);                // [R8] [R9]
    wire far_fault_eff  = gated_bit(~far_fault_bit, ~fiber_mode);            // [R11]
    wire heartbeat_eff  = gated_bit(heartbeat_bit, full_duplex);             // [R17]
    wire force_pol_eff  = gated_bit(auto_pol_bit, speed_100);                // [R18]
    wire jabber_eff     = gated_bit(~jabber_bit, full_duplex | speed_100);   // [R19]
    wire sd_conditioned = fiber_signal_detect ^ sd_pol_bit;                  // [R13]

    // control outputs, all registered; one cycle of lag is harmless
    // for these slow configuration levels
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            next_page_routing_r     <= 1'b0;
            energy_sense_enable_r   <= 1'b0;
            link_pulse_check_off_r  <= 1'b0;
            link_pulse_gen_off_r    <= 1'b0;
            scrambler_off_r         <= 1'b0;
            far_fault_enable_r      <= 1'b0;
            long_cable_threshold_r  <= 1'b0;
            signal_detect_r         <= 1'b0;
            crossover_swap_r        <= 1'b0;
            crossover_auto_r        <= 1'b0;
            heartbeat_test_active_r <= 1'b0;
            auto_polarity_enable_r  <= 1'b0;
            force_normal_polarity_r <= 1'b0;
            jabber_guard_active_r   <= 1'b0;
        end else begin
            next_page_routing_r     <= route_bit;                               // [R1]
            energy_sense_enable_r   <= energy_bit;                              // sense and pulse together [R6]
            link_pulse_check_off_r  <= lp_check_eff;                            // [R7]
            link_pulse_gen_off_r    <= lp_gen_eff;                              // [R8]
            scrambler_off_r         <= scram_bit;                               // [R10]
            far_fault_enable_r      <= far_fault_eff;                           // [R11]
            long_cable_threshold_r  <= long_cable_bit;                          // [R12]
            signal_detect_r         <= sd_conditioned;                          // [R13]
            crossover_swap_r        <= (xover_live_r == XOVER_SWAPPED);         // [R14]
            crossover_auto_r        <= xover_live_r[1];                         // 1x means automatic [R14]
            heartbeat_test_active_r <= heartbeat_eff;                           // [R17]
            auto_polarity_enable_r  <= ~auto_pol_bit;                           // [R18]
            force_normal_polarity_r <= force_pol_eff;                           // [R18]
            jabber_guard_active_r   <= jabber_eff;                              // [R19]
        end
    end

endmodule // pnc_regs

// ---- testbench/pnc_regs_chk.sv ----
// concurrent checks on the register bank ports
`timescale 1ns/100ps

module pnc_regs_chk
    import pnc_pkg::*;
(
    input wire logic              mclk,                    // system clock
    input wire logic              resetn,                  // hardware reset, active low
    input wire logic              reg_rd,                  // read strobe
    input wire logic              sw_reset,                // software reset pulse
    input wire logic              page_rx_valid,           // page strobe
    input wire logic [DATA_W-1:0] page_rx_code,            // page word
    input wire logic              aneg_enable,             // auto-negotiation on
    input wire logic              full_duplex,             // full duplex
    input wire logic              speed_100,               // 100 megabit
    input wire logic              fiber_mode,              // fiber, low is copper
    input wire logic [DATA_W-1:0] reg_rdata_r,             // read data
    input wire logic              base_page_load_r,        // base page pulse
    input wire logic [DATA_W-1:0] base_page_code_r,        // base page word
    input wire logic              link_pulse_check_off_r,  // check off
    input wire logic              link_pulse_gen_off_r,    // generation off
    input wire logic              far_fault_enable_r,      // far fault active
    input wire logic              heartbeat_test_active_r, // heartbeat running
    input wire logic              auto_polarity_enable_r,  // auto polarity on
    input wire logic              force_normal_polarity_r, // polarity forced
    input wire logic              jabber_guard_active_r,   // jabber active
    input wire logic              crossover_swap_r,        // swapped pairs
    input wire logic              crossover_auto_r         // auto crossover
);
    import pnc_pkg::*;

    // one domain, so clock and reset are given once
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    // read data stands only in the cycle after a strobe
    chk_rdata_one_cycle: assert property (!$past(reg_rd) |-> reg_rdata_r == RD_UNMAPPED) else $error("read data stood too long");
    // base page pulse carries the word that arrived a cycle before
    chk_base_page_word: assert property (base_page_load_r |-> $past(page_rx_valid) && base_page_code_r == $past(page_rx_code)) else $error("base page load wrong");
    // auto-negotiation masks both link pulse disables
    chk_lp_check_masked: assert property (link_pulse_check_off_r |-> !$past(aneg_enable)) else $error("pulse check off under aneg");
    chk_lp_gen_masked: assert property (link_pulse_gen_off_r |-> !$past(aneg_enable)) else $error("pulse gen off under aneg");
    // copper mode never shows far fault
    chk_far_fault_copper: assert property (far_fault_enable_r |-> $past(fiber_mode)) else $error("far fault in copper");
    // heartbeat never runs at full duplex
    chk_heartbeat_half: assert property (heartbeat_test_active_r |-> !$past(full_duplex)) else $error("heartbeat at full duplex");
    // jabber only at half duplex and 10 megabit
    chk_jabber_mode: assert property (jabber_guard_active_r |-> !$past(full_duplex) && !$past(speed_100)) else $error("jabber in wrong mode");
    // forcing polarity excludes auto correction and 100 megabit
    chk_polarity_force: assert property (force_normal_polarity_r |-> !auto_polarity_enable_r && !$past(speed_100)) else $error("polarity force wrong");
    // swapped and automatic crossover are exclusive codes
    chk_xover_code: assert property (!(crossover_swap_r && crossover_auto_r)) else $error("crossover both modes");
    // crossover moves only after a software or hardware reset
    chk_xover_moves: assert property (!$stable({crossover_swap_r, crossover_auto_r}) |-> $past(sw_reset) || $past(sw_reset, 2) || $past(sw_reset, 3) || !$past(resetn) || !$past(resetn, 2) || !$past(resetn, 3)) else $error("crossover changed without reset");
endmodule // pnc_regs_chk

bind pnc_regs pnc_regs_chk u_chk (.mclk, .resetn, .reg_rd, .sw_reset, .page_rx_valid, .page_rx_code, .aneg_enable,
    .full_duplex, .speed_100, .fiber_mode, .reg_rdata_r, .base_page_load_r, .base_page_code_r, .link_pulse_check_off_r,
    .link_pulse_gen_off_r, .far_fault_enable_r, .heartbeat_test_active_r, .auto_polarity_enable_r,
    .force_normal_polarity_r, .jabber_guard_active_r, .crossover_swap_r, .crossover_auto_r);

// ---- testbench/testbench.sv ----
// self-checking bench for the register bank
`timescale 1ns/100ps

module testbench;
    import pnc_pkg::*;

    logic mclk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, sw_reset = 1'b0;
    logic crossover_strap = 1'b1, fiber_strap = 1'b1, forced10_strap = 1'b0, page_rx_valid = 1'b0;
    logic aneg_enable = 1'b0, full_duplex = 1'b0, speed_100 = 1'b0, fiber_mode = 1'b0, fiber_signal_detect = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0, page_rx_code = '0, reg_rdata_r, base_page_code_r;
    logic base_page_load_r, next_page_routing_r, energy_sense_enable_r, link_pulse_check_off_r, link_pulse_gen_off_r;
    logic scrambler_off_r, far_fault_enable_r, long_cable_threshold_r, signal_detect_r, crossover_swap_r;
    logic crossover_auto_r, heartbeat_test_active_r, auto_polarity_enable_r, force_normal_polarity_r;
    logic jabber_guard_active_r;
    logic [11:0] outs;                 // packed control outputs for the table
    int n_errors = 0, checked = 0;     // mismatch and comparison counters
    // table rows: written control word, status {aneg,fd,s100,fib,sdet}, outputs
    logic [15:0] rw [5] = '{16'h0000, 16'h6a87, 16'h6a87, 16'h1140, 16'h0040};
    logic [4:0]  rs [5] = '{5'b00000, 5'b00011, 5'b11101, 5'b01010, 5'b00111};
    logic [11:0] ro [5] = '{12'h00a, 12'hff4, 12'h960, 12'h029, 12'h088};
    // reset rows: straps {xover,fiber,forced10} and control word expected
    logic [2:0]  ts [3] = '{3'b110, 3'b001, 3'b000};
    logic [15:0] te [3] = '{16'h0330, 16'h0300, 16'h0100};

    assign outs = {energy_sense_enable_r, link_pulse_check_off_r, link_pulse_gen_off_r, scrambler_off_r,
        far_fault_enable_r, long_cable_threshold_r, signal_detect_r, heartbeat_test_active_r,
        auto_polarity_enable_r, force_normal_polarity_r, jabber_guard_active_r, next_page_routing_r};

    // 200 MHz clock
    always #2.5 mclk = ~mclk;

    pnc_regs dut (.mclk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_r, .sw_reset, .crossover_strap,
        .fiber_strap, .forced10_strap, .page_rx_valid, .page_rx_code, .aneg_enable, .full_duplex, .speed_100,
        .fiber_mode, .fiber_signal_detect, .base_page_load_r, .base_page_code_r, .next_page_routing_r,
        .energy_sense_enable_r, .link_pulse_check_off_r, .link_pulse_gen_off_r, .scrambler_off_r,
        .far_fault_enable_r, .long_cable_threshold_r, .signal_detect_r, .crossover_swap_r, .crossover_auto_r,
        .heartbeat_test_active_r, .auto_polarity_enable_r, .force_normal_polarity_r, .jabber_guard_active_r);

    // compare with four-state equality so unknowns never match
    task chk(input logic [15:0] seen, input logic [15:0] want);
        checked++;
        if (seen !== want) begin
            n_errors++;
            $display("BAD %0t saw %h wanted %h", $time, seen, want);
        end
    endtask

    // one-cycle write strobe
    task wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    // one-cycle read strobe, data sampled in the following cycle
    task rd(input logic [ADDR_W-1:0] a, input logic [15:0] want);
        @(posedge mclk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata_r, want);
    endtask

    // one-cycle pulse on either the page or the software reset input
    task pulse(input bit page, input logic [15:0] code);
        @(posedge mclk);
        if (page) begin
            page_rx_valid <= 1'b1; page_rx_code <= code;
        end else begin
            sw_reset <= 1'b1;
        end
        @(posedge mclk);
        page_rx_valid <= 1'b0; sw_reset <= 1'b0;
        #1;
    endtask

    // verdict and end of run
    task complete_run();
        if (n_errors == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        // hardware reset under each strap set; the first holds 20 cycles
        for (int i = 0; i < 3; i++) begin
            @(posedge mclk);
            resetn <= 1'b0;
            {crossover_strap, fiber_strap, forced10_strap} <= ts[i];
            repeat (i == 0 ? 20 : 3) @(posedge mclk);
            resetn <= 1'b1;
            rd(OFS_PHY_CTRL, te[i]);
            rd(OFS_PARTNER_NP, NP_RESET);
            chk(16'(crossover_auto_r), 16'(ts[i][2]));
        end
        // ordinary control words against status levels
        for (int i = 0; i < 5; i++) begin
            @(posedge mclk);
            {aneg_enable, full_duplex, speed_100, fiber_mode, fiber_signal_detect} <= rs[i];
            wr(OFS_PHY_CTRL, rw[i]);
            rd(OFS_PHY_CTRL, rw[i]);
            chk(16'(outs), 16'(ro[i]));
        end
        // routing on: page lands in the partner register, write there is ignored
        wr(OFS_PHY_CTRL, 16'h1000);
        pulse(1'b1, 16'hc5a5);
        chk(16'(base_page_load_r), 16'h0000);
        wr(OFS_PARTNER_NP, 16'hffff);
        rd(OFS_PARTNER_NP, 16'hc5a5);
        // routing off: partner register clears and pages go to the base page
        wr(OFS_PHY_CTRL, 16'h0000);
        rd(OFS_PARTNER_NP, 16'h0000);
        pulse(1'b1, 16'h3a5a);
        chk({base_page_load_r, base_page_code_r[14:0]}, 16'hba5a);
        rd(OFS_PARTNER_NP, 16'h0000);
        // unmapped read gives zero
        rd(5'h03, RD_UNMAPPED);
        // crossover waits for software reset, which keeps only some fields
        wr(OFS_PHY_CTRL, 16'hffff);
        repeat (3) @(posedge mclk);
        #1 chk(16'(crossover_auto_r), 16'h0000);
        // every bit reads back, then the read data drop a cycle later
        rd(OFS_PHY_CTRL, 16'hffff);
        @(posedge mclk);
        #1 chk(reg_rdata_r, 16'h0000);
        pulse(1'b0, 16'h0000);
        repeat (3) @(posedge mclk);
        rd(OFS_PHY_CTRL, 16'hc37c);
        chk(16'({crossover_swap_r, crossover_auto_r}), 16'h0001);
        wr(OFS_PHY_CTRL, 16'h0010);
        pulse(1'b0, 16'h0000);
        repeat (3) @(posedge mclk);
        rd(OFS_PHY_CTRL, 16'h0010);
        chk(16'({crossover_swap_r, crossover_auto_r}), 16'h0002);
        complete_run();
    end
endmodule // testbench
